/* pkg/fciac_pkg.sv */
// fciac_pkg: register map, fields, patterns and timing of the ci alarm / irq block
// assumes a 125 MHz clock and a 32-bit ahb-lite register bus
package fciac_pkg;
    // ==========================================
    // register byte offsets
    localparam logic [7:0] OFS_POL = 8'h00;
    localparam logic [7:0] OFS_LCS = 8'h04;
    localparam logic [7:0] OFS_CIA = 8'h08;
    localparam logic [7:0] OFS_STS = 8'h0c;
    localparam logic [7:0] OFS_IEN = 8'h10;
    localparam logic [7:0] OFS_CLR = 8'h14;
    // ==========================================
    // fields and reset values
    localparam int POL_MASTER = 0;
    localparam int POL_AUTOCLR = 1;
    localparam int POL_CLRMODE = 2;
    localparam int CIA_RX_LO = 0;
    localparam int CIA_TX_LO = 2;
    localparam int STS_AIS = 0;
    localparam int STS_RAI = 1;
    localparam int STS_EXT = 2;
    localparam int STS_W = 3;
    localparam logic [2:0] POL_RST = 3'h0;
    localparam logic [1:0] LCS_RST = 2'h0;
    localparam logic [3:0] CIA_RST = 4'h0;
    localparam logic [2:0] STS_RST = 3'h0;
    // ==========================================
    // patterns, bit 0 goes out first
    localparam int AIS_SIG_W = 17;
    localparam logic [16:0] AIS_SIG = 17'h0f9ff;
    localparam int AIS_PERIOD = 386;
    localparam int RAI_W = 16;
    localparam logic [15:0] RAI_MSG = 16'h00ff;
    localparam logic [15:0] RAI_SIG = 16'h3eff;
    // ==========================================
    // timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS * 1000 / CLK_PERIOD_PS;
    localparam int RAI_MSG_MS = 990;
    localparam int RAI_SIG_MS = 90;
    localparam int RAI_CYCLE_MS = RAI_MSG_MS + RAI_SIG_MS;
    // ==========================================
    // alarm modes
    typedef enum logic [2:0] {
        CI_OFF = 3'h1,
        CI_AIS = 3'h2,
        CI_RAI = 3'h4
    } fciac_mode_t;

    function automatic fciac_mode_t fciac_decode(input logic [1:0] f);
        case (f)
            2'h1: return CI_AIS;
            2'h2: return CI_RAI;
            default: return CI_OFF;
        endcase
    endfunction : fciac_decode
endpackage : fciac_pkg

/* pkg/fciac_alarm_if.sv */
// fciac_alarm_if: mode, tick and event wires between control and alarm engines
// assumes all parties run on the one block clock
`timescale 1ns/1ps
`default_nettype none
interface fciac_alarm_if;
    fciac_pkg::fciac_mode_t tx_mode;
    fciac_pkg::fciac_mode_t rx_mode;
    logic ms_tick;
    logic ais_evt;
    logic rai_evt;
    modport ctrl (output tx_mode, output rx_mode, output ms_tick, input ais_evt, input rai_evt);
    modport gen (input tx_mode, input ms_tick);
    modport det (input rx_mode, output ais_evt, output rai_evt);
endinterface : fciac_alarm_if
`default_nettype wire

/* hdl/fciac_ci_tx.sv */
// fciac_ci_tx: ais-ci / rai-ci pattern generator on the transmit bit stream
// assumes bit_en pulses once per line bit and mode is already esf-gated
`timescale 1ns/1ps
`default_nettype none
module fciac_ci_tx (
    input wire logic clk,
    input wire logic rstn,
    fciac_alarm_if.gen ai,
    input wire logic bit_en,
    input wire logic data_in,
    output logic data_out
);
    logic [8:0] pos_q;
    logic [3:0] idx_q;
    logic [10:0] ms_q;
    logic out_q;
    wire is_ais = ai.tx_mode == fciac_pkg::CI_AIS;
    wire is_rai = ai.tx_mode == fciac_pkg::CI_RAI;
    wire pos_end = pos_q == 9'(fciac_pkg::AIS_PERIOD - 1);
    wire ms_end = ms_q == 11'(fciac_pkg::RAI_CYCLE_MS - 1);
    wire sig_ph = ms_q >= 11'(fciac_pkg::RAI_MSG_MS);
    wire in_sig = pos_q < 9'(fciac_pkg::AIS_SIG_W);
    wire ais_bit = in_sig ? fciac_pkg::AIS_SIG[pos_q[4:0]] : 1'b1;
    wire [15:0] rai_word = sig_ph ? fciac_pkg::RAI_SIG : fciac_pkg::RAI_MSG;
    assign data_out = out_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pos_q <= 9'h000;
            idx_q <= 4'h0;
            ms_q <= 11'h000;
            out_q <= 1'b1;
        end else begin
            pos_q <= !is_ais ? 9'h000 : bit_en ? (pos_end ? 9'h000 : pos_q + 9'h001) : pos_q;
            idx_q <= !is_rai ? 4'h0 : bit_en ? idx_q + 4'h1 : idx_q;
            ms_q <= !is_rai ? 11'h000 : ai.ms_tick ? (ms_end ? 11'h000 : ms_q + 11'h001) : ms_q;
            out_q <= is_ais ? (bit_en ? ais_bit : out_q) : is_rai ? (bit_en ? rai_word[idx_q] : out_q) : data_in;
        end
    end
    a_ais_ones_fill: assert property (@(posedge clk) disable iff (!rstn)
        is_ais && bit_en && !in_sig |=> data_out) else $error("ais fill bit not one");
    a_rai_cycle_len: assert property (@(posedge clk) disable iff (!rstn)
        is_rai && ai.ms_tick && ms_end |=> ms_q == 11'h000) else $error("rai cycle length wrong");
    a_rai_msg_zero: assert property (@(posedge clk) disable iff (!rstn)
        is_rai && bit_en && !sig_ph && idx_q[3] |=> !data_out) else $error("rai message high byte not zero");
endmodule : fciac_ci_tx
`default_nettype wire

/* hdl/fciac_ci_rx.sv */
// fciac_ci_rx: ais-ci / rai-ci signature detector on the receive bit stream
// assumes bit_en pulses once per line bit and mode is already esf-gated
`timescale 1ns/1ps
`default_nettype none
module fciac_ci_rx #(
    parameter int AIS_HITS = 3,
    parameter int RAI_HITS = 4
) (
    input wire logic clk,
    input wire logic rstn,
    fciac_alarm_if.det ai,
    input wire logic bit_en,
    input wire logic data_in
);
    logic [16:0] sr_q;
    logic [8:0] gap_q;
    logic [3:0] hit_q;
    logic ais_ev_q;
    logic rai_ev_q;
    fciac_pkg::fciac_mode_t mode_q;
    if (AIS_HITS < 1 || AIS_HITS > 15 || RAI_HITS < 1 || RAI_HITS > 15) begin : g_bad
        $error("hit counts must lie in 1..15");
    end
    wire [16:0] sr_d = {data_in, sr_q[16:1]};
    wire is_ais = ai.rx_mode == fciac_pkg::CI_AIS;
    wire is_rai = ai.rx_mode == fciac_pkg::CI_RAI;
    wire match = is_ais ? sr_d == fciac_pkg::AIS_SIG : is_rai & (sr_d[16:1] == fciac_pkg::RAI_SIG);
    wire [8:0] span = is_ais ? 9'(fciac_pkg::AIS_PERIOD - 1) : 9'(fciac_pkg::RAI_W - 1);
    wire [3:0] need = is_ais ? 4'(AIS_HITS) : 4'(RAI_HITS);
    wire hit = bit_en & match;
    wire [3:0] hit_d = gap_q == span ? (hit_q == need ? hit_q : hit_q + 4'h1) : 4'h1;
    wire arrive = hit & (hit_d == need) & (hit_q != need);
    assign ai.ais_evt = ais_ev_q;
    assign ai.rai_evt = rai_ev_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sr_q <= 17'h00000;
            gap_q <= 9'h000;
            hit_q <= 4'h0;
            ais_ev_q <= 1'b0;
            rai_ev_q <= 1'b0;
            mode_q <= fciac_pkg::CI_OFF;
        end else begin
            mode_q <= ai.rx_mode;
            ais_ev_q <= arrive & is_ais;
            rai_ev_q <= arrive & is_rai;
            if (ai.rx_mode != mode_q) begin
                sr_q <= 17'h00000;
                gap_q <= 9'h000;
                hit_q <= 4'h0;
            end else if (bit_en) begin
                sr_q <= sr_d;
                gap_q <= hit ? 9'h000 : (gap_q == 9'h1ff ? gap_q : gap_q + 9'h001);
                hit_q <= hit ? hit_d : (gap_q > span ? 4'h0 : hit_q);
            end
        end
    end
endmodule : fciac_ci_rx
`default_nettype wire

/* hdl/fciac_ctrl.sv */
// fciac_ctrl: per-channel interrupt policy, hdlc controller select and
// customer-installation alarm control, reached over ahb-lite
// assumes line bit enables and esf indication come from the framer datapath
//
// Contract
// - clear-mode 0: reading status clears every status bit read.
// - clear-mode 1: reads keep status; only writes clear it.
// - autoclear 0: enables stay set after status is read.
// - autoclear 1: enable bits drop when matching status is read.
// - master enable 0 blocks every interrupt of the channel.
// - hdlc select 00/11 first, 01 second, 10 third controller.
// - ci alarms generated and detected only in esf framing.
// - ais-ci: all ones with 17-bit signature every 386 bits.
// - rai-ci: 1.08 s cycle, 0.99 s message then 90 ms signature.
// - rai message 00000000 11111111, signature 00111110 11111111, lsb first.
// - transmit field bits 3:2 picks off, ais-ci or rai-ci.
// - detect field 00/11 off, 01 ais-ci, 10 rai-ci.
`timescale 1ns/1ps
`default_nettype none
module fciac_ctrl #(
    parameter int MS_CYCLES = fciac_pkg::MS_CYCLES,
    parameter int AIS_HITS = 3,
    parameter int RAI_HITS = 4
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic ESF_MODE,
    input wire logic EXT_EVENT,
    input wire logic TX_BIT_EN,
    input wire logic TX_DATA_IN,
    output logic TX_DATA_OUT,
    input wire logic RX_BIT_EN,
    input wire logic RX_DATA_IN,
    output logic [2:0] HDLC_SEL,
    output logic IRQ
);
    localparam int MSW = $clog2(MS_CYCLES + 1);

    if (MS_CYCLES < 2) begin : g_bad
        $error("MS_CYCLES must be at least 2");
    end

    // ==========================================
    // state
    logic wr_q;
    logic [7:0] wa_q;
    logic [2:0] pol_q;
    logic [1:0] lcs_q;
    logic [3:0] cia_q;
    logic [2:0] sts_q;
    logic [2:0] ien_q;
    logic [31:0] rdata_q;
    logic [MSW-1:0] ms_cnt_q;
    logic ms_tick_q;

    fciac_alarm_if ai ();

    function automatic logic hit_at(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction : hit_at

    // ==========================================
    // ahb-lite address phase
    wire addr_ph = HSEL & HREADY & HTRANS[1];
    wire word_ok = HADDR[31:8] == 24'h000000;
    wire rd_acc = addr_ph & ~HWRITE;
    wire wr_acc = addr_ph & HWRITE & word_ok;
    wire [7:0] ra = HADDR[7:0];
    wire rd_sts = rd_acc & word_ok & hit_at(ra, fciac_pkg::OFS_STS);

    // ==========================================
    // ahb-lite data phase writes
    wire [7:0] wd = HWDATA[7:0];
    wire [2:0] clr_bits = wd[2:0];
    wire wr_pol = wr_q & hit_at(wa_q, fciac_pkg::OFS_POL);
    wire wr_lcs = wr_q & hit_at(wa_q, fciac_pkg::OFS_LCS);
    wire wr_cia = wr_q & hit_at(wa_q, fciac_pkg::OFS_CIA);
    wire wr_ien = wr_q & hit_at(wa_q, fciac_pkg::OFS_IEN);
    wire wr_clr = wr_q & hit_at(wa_q, fciac_pkg::OFS_CLR);

    // ==========================================
    // read selection
    wire [7:0] rsel =
        ({8{hit_at(ra, fciac_pkg::OFS_POL)}} & {5'h00, pol_q}) |
        ({8{hit_at(ra, fciac_pkg::OFS_LCS)}} & {6'h00, lcs_q}) |
        ({8{hit_at(ra, fciac_pkg::OFS_CIA)}} & {4'h0, cia_q}) |
        ({8{hit_at(ra, fciac_pkg::OFS_STS)}} & {5'h00, sts_q}) |
        ({8{hit_at(ra, fciac_pkg::OFS_IEN)}} & {5'h00, ien_q});
    wire [31:0] rdata_d = rd_acc ? {24'h000000, word_ok ? rsel : 8'h00} : rdata_q;

    assign HRDATA = rdata_q;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // ==========================================
    // interrupt policy
    wire master = pol_q[fciac_pkg::POL_MASTER];
    wire autoclr = pol_q[fciac_pkg::POL_AUTOCLR];
    wire wclr_mode = pol_q[fciac_pkg::POL_CLRMODE];

    wire [2:0] evt;
    assign evt[fciac_pkg::STS_AIS] = ai.ais_evt;
    assign evt[fciac_pkg::STS_RAI] = ai.rai_evt;
    assign evt[fciac_pkg::STS_EXT] = EXT_EVENT;

    // clear on read only outside write-to-clear mode
    wire [2:0] rd_clr = (rd_sts & ~wclr_mode) ? sts_q : 3'h0;
    // clear register acts only in write-to-clear mode
    wire [2:0] wr_clr_bits = (wr_clr & wclr_mode) ? clr_bits : 3'h0;
    // new events win over a clear in the same cycle
    wire [2:0] sts_d = (sts_q & ~(rd_clr | wr_clr_bits)) | evt;

    // enables drop with their status read only under autoclear
    wire [2:0] en_drop = (rd_sts & autoclr) ? sts_q : 3'h0;
    wire [2:0] ien_d = wr_ien ? wd[2:0] : (ien_q & ~en_drop);

    assign IRQ = master & (|(sts_q & ien_q));

    // ==========================================
    // hdlc controller select, one-hot
    assign HDLC_SEL = {lcs_q == 2'h2, lcs_q == 2'h1, lcs_q[1] == lcs_q[0]};

    // ==========================================
    // alarm modes, forced off outside esf
    wire [1:0] tx_field = cia_q[fciac_pkg::CIA_TX_LO +: 2];
    wire [1:0] rx_field = cia_q[fciac_pkg::CIA_RX_LO +: 2];
    assign ai.tx_mode = ESF_MODE ? fciac_pkg::fciac_decode(tx_field) : fciac_pkg::CI_OFF;
    assign ai.rx_mode = ESF_MODE ? fciac_pkg::fciac_decode(rx_field) : fciac_pkg::CI_OFF;
    assign ai.ms_tick = ms_tick_q;

    // ==========================================
    // millisecond divider
    wire ms_wrap = ms_cnt_q == MSW'(MS_CYCLES - 1);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ms_cnt_q <= '0;
            ms_tick_q <= 1'b0;
        end else begin
            ms_cnt_q <= ms_wrap ? '0 : ms_cnt_q + MSW'(1);
            ms_tick_q <= ms_wrap;
        end
    end

    // ==========================================
    // bus pipeline and read data
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            rdata_q <= 32'h00000000;
        end else begin
            wr_q <= wr_acc;
            wa_q <= wr_acc ? ra : wa_q;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================
    // configuration registers
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pol_q <= fciac_pkg::POL_RST;
            lcs_q <= fciac_pkg::LCS_RST;
            cia_q <= fciac_pkg::CIA_RST;
        end else begin
            pol_q <= wr_pol ? wd[2:0] : pol_q;
            lcs_q <= wr_lcs ? wd[1:0] : lcs_q;
            cia_q <= wr_cia ? wd[3:0] : cia_q;
        end
    end

    // ==========================================
    // status and enable registers
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sts_q <= fciac_pkg::STS_RST;
            ien_q <= 3'h0;
        end else begin
            sts_q <= sts_d;
            ien_q <= ien_d;
        end
    end

    // ==========================================
    // alarm engines
    fciac_ci_tx u_tx (
        .clk(CLK),
        .rstn(RSTN),
        .ai(ai.gen),
        .bit_en(TX_BIT_EN),
        .data_in(TX_DATA_IN),
        .data_out(TX_DATA_OUT)
    );

    fciac_ci_rx #(
        .AIS_HITS(AIS_HITS),
        .RAI_HITS(RAI_HITS)
    ) u_rx (
        .clk(CLK),
        .rstn(RSTN),
        .ai(ai.det),
        .bit_en(RX_BIT_EN),
        .data_in(RX_DATA_IN)
    );

    // ==========================================
    // checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    sequence s_master_off;
        wr_pol && !wd[fciac_pkg::POL_MASTER];
    endsequence

    sequence s_rx_quiet;
        (!ai.ais_evt && !ai.rai_evt) [*4];
    endsequence

    a_irq_master_off: assert property (
        s_master_off |=> !IRQ) else $error("irq high with master enable off");

    a_irq_raise: assert property (
        ai.ais_evt && master && ien_q[fciac_pkg::STS_AIS] && !wr_ien && !wr_pol && !rd_sts |=> IRQ)
        else $error("enabled event did not raise irq");

    a_read_clear: assert property (
        rd_sts && !wclr_mode |=> (sts_q & ~$past(evt)) == 3'h0) else $error("status not cleared by read");

    a_wclr_hold: assert property (
        rd_sts && wclr_mode && !wr_clr |=> (sts_q & $past(sts_q)) == $past(sts_q))
        else $error("status lost on read in write-clear mode");

    a_write_clear: assert property (
        wr_clr && wclr_mode |=> (sts_q & $past(clr_bits) & ~$past(evt)) == 3'h0)
        else $error("status not cleared by write");

    a_en_keep: assert property (
        rd_sts && !autoclr && !wr_ien |=> ien_q == $past(ien_q)) else $error("enable changed on status read");

    a_en_drop: assert property (
        rd_sts && autoclr && !wr_ien |=> (ien_q & $past(sts_q)) == 3'h0) else $error("enable not auto-cleared");

    a_hdlc_route: assert property (
        wr_lcs && wd[1:0] == 2'h3 |=> HDLC_SEL == 3'h1) else $error("code 11 did not pick first controller");

    a_esf_gate: assert property (
        !ESF_MODE |=> TX_DATA_OUT == $past(TX_DATA_IN)) else $error("ci alarm sent outside esf");

    a_tx_off_code: assert property (
        tx_field == 2'h3 |=> TX_DATA_OUT == $past(TX_DATA_IN)) else $error("code 11 did not disable generation");

    a_rx_off_code: assert property (
        wr_cia && wd[1:0] == 2'h3 |=> ##1 s_rx_quiet) else $error("detection active after off code");

    sequence s_no_alarm_evt;
        !ai.ais_evt && !ai.rai_evt;
    endsequence

    a_bus_okay_ready: assert property (
        HREADYOUT && !HRESP)
        else $error("bus not ready or not okay");

    a_hdlc_onehot: assert property (
        $onehot(HDLC_SEL))
        else $error("hdlc select not one-hot");

    a_hdlc_first: assert property (
        wr_lcs && wd[1:0] == 2'h0 |=> HDLC_SEL == 3'h1)
        else $error("code 00 did not pick first controller");

    a_hdlc_second: assert property (
        wr_lcs && wd[1:0] == 2'h1 |=> HDLC_SEL == 3'h2)
        else $error("code 01 did not pick second controller");

    a_hdlc_third: assert property (
        wr_lcs && wd[1:0] == 2'h2 |=> HDLC_SEL == 3'h4)
        else $error("code 10 did not pick third controller");

    a_irq_gate_low: assert property (
        !master |-> !IRQ)
        else $error("irq high while master enable low");

    a_irq_needs_enable: assert property (
        IRQ |-> (sts_q & ien_q) != 3'h0)
        else $error("irq high with no enabled status");

    a_irq_ext_raise: assert property (
        EXT_EVENT && master && ien_q[fciac_pkg::STS_EXT] && !wr_ien && !wr_pol && !rd_sts |=> IRQ)
        else $error("enabled external event did not raise irq");

    a_rx_esf_off: assert property (
        !ESF_MODE |=> s_no_alarm_evt)
        else $error("ci alarm detected outside esf");

    a_mode_esf_off: assert property (
        !ESF_MODE |-> ai.tx_mode == fciac_pkg::CI_OFF && ai.rx_mode == fciac_pkg::CI_OFF)
        else $error("alarm mode active outside esf");

    a_rx_ais_sel: assert property (
        ESF_MODE && rx_field == 2'h1 |-> ai.rx_mode == fciac_pkg::CI_AIS)
        else $error("detect code 01 did not select ais-ci");

    a_rx_rai_sel: assert property (
        ESF_MODE && rx_field == 2'h2 |-> ai.rx_mode == fciac_pkg::CI_RAI)
        else $error("detect code 10 did not select rai-ci");

    a_tx_ais_sel: assert property (
        ESF_MODE && tx_field == 2'h1 |-> ai.tx_mode == fciac_pkg::CI_AIS)
        else $error("transmit code 01 did not select ais-ci");

    a_tx_rai_sel: assert property (
        ESF_MODE && tx_field == 2'h2 |-> ai.tx_mode == fciac_pkg::CI_RAI)
        else $error("transmit code 10 did not select rai-ci");

    a_tx_off_zero: assert property (
        tx_field == 2'h0 |=> TX_DATA_OUT == $past(TX_DATA_IN))
        else $error("code 00 did not disable generation");

    a_ms_tick_single: assert property (
        ai.ms_tick |=> !ai.ms_tick)
        else $error("millisecond tick longer than one cycle");

    a_sts_wclr_keep: assert property (
        wclr_mode && !wr_clr |=> (sts_q & $past(sts_q)) == $past(sts_q))
        else $error("status lost without clear write");

    a_en_write_wins: assert property (
        wr_ien |=> ien_q == $past(wd[2:0]))
        else $error("enable write not taken");

endmodule : fciac_ctrl
`default_nettype wire

/* tb/framer_irq_hdlc_ci_alarm_ctrl_bench.sv */
// framer_irq_hdlc_ci_alarm_ctrl_bench: self-checking bench for fciac_ctrl
// assumes the design package is compiled first; drives ahb-lite and bit streams
`timescale 1ns/1ps
`default_nettype none
module framer_irq_hdlc_ci_alarm_ctrl_bench;
    // ==========================================
    // signals
    logic clk, rstn, hsel, hwrite, esf, ext, txen, txin, rxen, rxin;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, hdlc;
    logic hreadyout, hresp, txout, irq;
    logic bits[$];
    int n_mismatch, n_checks;

    fciac_ctrl #(.MS_CYCLES(20)) dut (.CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .ESF_MODE(esf), .EXT_EVENT(ext), .TX_BIT_EN(txen),
        .TX_DATA_IN(txin), .TX_DATA_OUT(txout), .RX_BIT_EN(rxen), .RX_DATA_IN(rxin), .HDLC_SEL(hdlc),
        .IRQ(irq));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================
    // common tasks
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 100) begin
                n_mismatch++;
                final_report;
            end
            @(posedge clk);
        end
    endtask : wait_rdy

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
    endtask : ahb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask : rdchk

    task automatic pulse_ext;
        ext <= 1'b1;
        @(posedge clk);
        ext <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse_ext

    task automatic tx_collect(input int nb);
        bits.delete();
        for (int i = 0; i < nb; i++) begin
            txen <= 1'b1;
            @(posedge clk);
            txen <= 1'b0;
            repeat (2) @(posedge clk);
            bits.push_back(txout);
        end
    endtask : tx_collect

    task automatic rx_bit(input logic b);
        rxin <= b;
        rxen <= 1'b1;
        @(posedge clk);
        rxen <= 1'b0;
        @(posedge clk);
    endtask : rx_bit

    // ==========================================
    // scenarios
    task automatic t_reset;
        logic [7:0] ofs[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h40};
        foreach (ofs[i]) rdchk(ofs[i], 32'h00000000);
        chk({29'h0, hdlc}, 32'h00000001);
        chk({31'h0, irq}, 32'h00000000);
        chk({31'h0, hresp}, 32'h00000000);
    endtask : t_reset

    task automatic t_hdlc;
        logic [2:0] exp[4] = '{3'h1, 3'h2, 3'h4, 3'h1};
        for (int c = 0; c < 4; c++) begin
            ahb(1'b1, 8'h04, c);
            @(posedge clk);
            chk({29'h0, hdlc}, {29'h0, exp[c]});
            rdchk(8'h04, c);
        end
    endtask : t_hdlc

    task automatic t_irq_read;
        ahb(1'b1, 8'h10, 32'h00000004);
        pulse_ext;
        chk({31'h0, irq}, 32'h00000000);
        ahb(1'b1, 8'h00, 32'h00000001);
        @(posedge clk);
        chk({31'h0, irq}, 32'h00000001);
        rdchk(8'h0c, 32'h00000004);
        @(posedge clk);
        chk({31'h0, irq}, 32'h00000000);
        rdchk(8'h0c, 32'h00000000);
        rdchk(8'h10, 32'h00000004);
    endtask : t_irq_read

    task automatic t_irq_wc;
        ahb(1'b1, 8'h00, 32'h00000007);
        pulse_ext;
        chk({31'h0, irq}, 32'h00000001);
        rdchk(8'h0c, 32'h00000004);
        rdchk(8'h0c, 32'h00000004);
        rdchk(8'h10, 32'h00000000);
        @(posedge clk);
        chk({31'h0, irq}, 32'h00000000);
        ahb(1'b1, 8'h14, 32'h00000004);
        rdchk(8'h0c, 32'h00000000);
        ahb(1'b1, 8'h00, 32'h00000001);
    endtask : t_irq_wc

    task automatic t_tx_off;
        logic [1:0] cds[3] = '{2'h0, 2'h3, 2'h1};
        txin <= 1'b0;
        foreach (cds[i]) begin
            esf <= (i < 2);
            ahb(1'b1, 8'h08, {28'h0, cds[i], 2'h0});
            tx_collect(20);
            foreach (bits[k]) chk({31'h0, bits[k]}, 32'h00000000);
        end
        esf <= 1'b1;
    endtask : t_tx_off

    task automatic t_tx_ais;
        int zeros = 0, found = 0;
        logic [16:0] win;
        ahb(1'b1, 8'h08, 32'h00000004);
        tx_collect(2 * fciac_pkg::AIS_PERIOD + 17);
        for (int i = 0; i < fciac_pkg::AIS_PERIOD; i++) begin
            zeros += (bits[i] == 1'b0);
            for (int k = 0; k < 17; k++) win[k] = bits[i + k];
            found += (win == fciac_pkg::AIS_SIG);
            chk({31'h0, bits[i]}, {31'h0, bits[i + fciac_pkg::AIS_PERIOD]});
        end
        chk(zeros, 17 - $countones(fciac_pkg::AIS_SIG));
        chk(found, 1);
    endtask : t_tx_ais

    task automatic t_tx_rai;
        int ms, n_msg = 0, n_sig = 0, n_bad = 0;
        logic [15:0] sr = 16'h0000;
        ahb(1'b1, 8'h08, 32'h00000008);
        for (int i = 0; i < 1095 * 20 / 3; i++) begin
            tx_collect(1);
            sr = {bits[0], sr[15:1]};
            ms = i * 3 / 20;
            if ((ms > 5 && ms < 980) || ms > 1085) begin
                n_msg += (sr == fciac_pkg::RAI_MSG);
                n_bad += (sr == fciac_pkg::RAI_SIG);
            end
            if (ms > 1000 && ms < 1075) n_sig += (sr == fciac_pkg::RAI_SIG);
        end
        chk(n_bad, 0);
        chk(n_msg > 0, 1);
        chk(n_sig > 0, 1);
        ahb(1'b1, 8'h08, 32'h00000000);
    endtask : t_tx_rai

    task automatic t_rx(input logic e, input logic [1:0] sel, input logic [31:0] exp);
        esf <= e;
        ahb(1'b1, 8'h10, 32'h00000003);
        ahb(1'b1, 8'h08, {30'h0, sel});
        for (int f = 0; f < 5; f++) begin
            for (int p = 0; p < fciac_pkg::AIS_PERIOD; p++) begin
                rx_bit((sel == 2'h1) ? ((p < 17) ? fciac_pkg::AIS_SIG[p] : 1'b1) : fciac_pkg::RAI_SIG[p % 16]);
            end
        end
        repeat (4) @(posedge clk);
        chk({31'h0, irq}, {31'h0, exp != 32'h00000000});
        rdchk(8'h0c, exp);
    endtask : t_rx

    // ==========================================
    // main sequence
    initial begin
        n_mismatch = 0;
        n_checks = 0;
        rstn = 1'b0;
        {hsel, hwrite, ext, txen, txin, rxen, rxin} = 7'h00;
        esf = 1'b1;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        htrans = 2'h0;
        hsize = 3'h2;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset;
        t_hdlc;
        t_irq_read;
        t_irq_wc;
        t_tx_off;
        t_tx_ais;
        t_tx_rai;
        t_rx(1'b0, 2'h1, 32'h00000000);
        t_rx(1'b1, 2'h1, 32'h00000001);
        t_rx(1'b1, 2'h2, 32'h00000002);
        t_rx(1'b1, 2'h3, 32'h00000000);
        final_report;
    end
endmodule : framer_irq_hdlc_ci_alarm_ctrl_bench
`default_nettype wire
